// File: tb/pmc_far_side.sv
// Far side model: wake pins, reset pin, event lines and pad values.
// Assumes the bench calls its tasks between clock edges.
`timescale 1ns/100ps
`default_nettype none
module pmc_far_side (
  input wire logic clk,
  output logic pin_reset_n,
  output logic [31:0] wake_pins,
  output logic [2:0] ev,
  output logic [31:0] gpio_live
);
  initial
  begin
    pin_reset_n = 1'b1;
    wake_pins = 32'h0;
    ev = 3'h0;
    gpio_live = 32'h0;
  end
  // Events are held four edges, since a shorter pulse can slip past the sync.
  task automatic fire(input int k);
    @(posedge clk);
    if (k == 3)
      wake_pins <= ~wake_pins;
    else
      ev[k] <= 1'b1;
    repeat (4) @(posedge clk);
    ev <= 3'h0;
  endtask
  task automatic pads(input logic [31:0] v);
    @(posedge clk);
    gpio_live <= v;
  endtask
  task automatic hold_reset();
    @(posedge clk);
    pin_reset_n <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/pmc_power_mode_controller_assertions.sv
// Checker for the power mode controller outputs.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pmc_checker (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PIN_RESET_N,
  input wire logic CPU_CLK_EN,
  input wire logic CPU_RESUME,
  input wire logic FLASH_PWR,
  input wire logic RADIO_EN,
  input wire logic FAST_CLK_EN,
  input wire logic SLOW_CLK_EN,
  input wire logic SENSOR_PWR,
  input wire logic ALWAYS_ON_PWR,
  input wire logic SYS_RESET_N,
  input wire logic GPIO_LATCH,
  input wire logic [31:0] GPIO_HOLD_VAL,
  input wire logic [3:0] SRAM_PWR,
  input wire logic PERIPH_PWR,
  input wire logic POR_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Remembers an off state since the processor last ran, so a reset-like wake is known.
  logic off_seen_ff;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      off_seen_ff <= 1'b0;
    else if (!SYS_RESET_N)
      off_seen_ff <= 1'b1;
    else if (CPU_CLK_EN)
      off_seen_ff <= 1'b0;
  end
  chk_radio_fast: assert property (RADIO_EN |-> FAST_CLK_EN)
    else $error("radio on without fast clock");
  chk_fast_slow: assert property (FAST_CLK_EN |-> SLOW_CLK_EN)
    else $error("fast clock without slow clock");
  chk_sensor_aon: assert property (SENSOR_PWR |-> ALWAYS_ON_PWR)
    else $error("sensor powered without always-on domain");
  chk_flash_fast: assert property (FLASH_PWR |-> FAST_CLK_EN && SYS_RESET_N)
    else $error("flash powered in a sleep state");
  chk_cpu_run: assert property (CPU_CLK_EN |-> PERIPH_PWR && SRAM_PWR == 4'hF)
    else $error("cpu clocked without its domains");
  chk_off_state: assert property (!SYS_RESET_N && POR_EN |-> !ALWAYS_ON_PWR
    && !SENSOR_PWR && !SLOW_CLK_EN && SRAM_PWR == 4'h0) else $error("domain alive in shutdown");
  chk_held_state: assert property (!POR_EN |-> !SYS_RESET_N && !SLOW_CLK_EN
    && SRAM_PWR == 4'h0 && !FLASH_PWR) else $error("domain alive while reset pin held");
  chk_pin_reset: assert property ((!PIN_RESET_N) [*4] |-> !SYS_RESET_N)
    else $error("reset pin not obeyed");
  chk_latch_hold: assert property (GPIO_LATCH && $past(GPIO_LATCH) |-> $stable(GPIO_HOLD_VAL))
    else $error("latched pads changed");
  chk_cpu_resume: assert property ($rose(CPU_CLK_EN) && off_seen_ff |-> !CPU_RESUME)
    else $error("resume after an off state");
endmodule
bind pmc_power_mode_controller pmc_checker chk (.CLK(CLK), .RESET_N(RESET_N),
  .PIN_RESET_N(PIN_RESET_N), .CPU_CLK_EN(CPU_CLK_EN), .CPU_RESUME(CPU_RESUME),
  .FLASH_PWR(FLASH_PWR), .RADIO_EN(RADIO_EN), .FAST_CLK_EN(FAST_CLK_EN),
  .SLOW_CLK_EN(SLOW_CLK_EN), .SENSOR_PWR(SENSOR_PWR), .ALWAYS_ON_PWR(ALWAYS_ON_PWR),
  .SYS_RESET_N(SYS_RESET_N), .GPIO_LATCH(GPIO_LATCH), .GPIO_HOLD_VAL(GPIO_HOLD_VAL),
  .SRAM_PWR(SRAM_PWR), .PERIPH_PWR(PERIPH_PWR), .POR_EN(POR_EN));
`default_nettype wire

// File: tb/power_mode_controller_bench.sv
// Bench for the power mode controller: APB master, table, mode scenarios.
// Assumes the far side model drives pins and events.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module power_mode_controller_bench;
  import pmc_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic e;} pmc_row_t;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, err, latch, cpu, resume, flash;
  logic radio, fast, fsel, pll, slow, ssel, periph, always_on_domain, sens, regr, cram, por, sysr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, hv, wpins, live, pad;
  logic [2:0] ev;
  logic [3:0] sram;
  int failures, total_checks, cycles;
  pmc_row_t rows [0:13] = '{{1'b0, 8'h08, 32'h1, 1'b0}, {1'b1, 8'h08, 32'h1, 1'b0},
    {1'b0, 8'h08, 32'h0, 1'b0}, {1'b1, 8'h0C, 32'h5, 1'b0}, {1'b0, 8'h0C, 32'h5, 1'b0},
    {1'b1, 8'h10, 32'h1, 1'b0}, {1'b0, 8'h10, 32'h1, 1'b0}, {1'b1, 8'h14, 32'h2, 1'b0},
    {1'b0, 8'h14, 32'h2, 1'b0}, {1'b1, 8'h04, 32'hFF, 1'b0}, {1'b0, 8'h04, 32'h1, 1'b0},
    {1'b0, 8'h20, 32'h0, 1'b1}, {1'b1, 8'h00, 32'h4, 1'b0}, {1'b0, 8'h00, 32'h4, 1'b0}};
  wire logic pin_rn;
  pmc_far_side far (.clk(clk), .pin_reset_n(pin_rn), .wake_pins(wpins), .ev(ev),
    .gpio_live(live));
  pmc_power_mode_controller dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_RESET_N(pin_rn), .WAKE_PINS(wpins), .IRQ_ANY(ev[0]),
    .RTC_EVENT(ev[1]), .SENSOR_EVENT(ev[2]), .GPIO_LIVE(live), .GPIO_HOLD_VAL(hv),
    .GPIO_LATCH(latch), .CPU_CLK_EN(cpu), .CPU_RESUME(resume), .FLASH_PWR(flash),
    .RADIO_EN(radio), .FAST_CLK_EN(fast), .FAST_CLK_SEL_RC(fsel), .PLL_DOUBLER_EN(pll),
    .SLOW_CLK_EN(slow), .SLOW_CLK_SEL_RC(ssel), .PERIPH_PWR(periph), .ALWAYS_ON_PWR(always_on_domain),
    .SENSOR_PWR(sens), .REG_RETAIN(regr), .SRAM_PWR(sram), .CACHE_AS_RAM(cram),
    .BROWNOUT_EN(), .POR_EN(por), .SYS_RESET_N(sysr));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Latency is counted from the end of the event, so a few cycles of sync slack.
  task automatic wake(input int lo);
    int n;
    n = 0;
    while (cpu !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n > lo - 8 && n < lo + 8, 1'b1)
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    {rst_n, psel, pen, pwr, paddr, pwdata} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK(err, rows[i].e)
      if (!rows[i].w) `CHK(rd, rows[i].d)
    end
    @(negedge clk);
    `CHK({fsel, ssel, pll, cram, regr, por, cpu}, 7'h3F)
    apb(1'b1, REG_CTRL, 32'h5);
    repeat (3) @(negedge clk);
    `CHK({cpu, periph}, 2'h1)
    far.fire(0);
    wake(IDLE_WAKE_CYC);
    for (int k = 1; k < 4; k++)
    begin
      pad = 32'hA5A5_0F0F ^ k;
      far.pads(pad);
      apb(1'b1, REG_CTRL, 32'h6);
      repeat (3) @(negedge clk);
      `CHK({latch, always_on_domain, sens, slow, sram, hv}, {8'hF5, pad})
      `CHK({cpu, periph, fast, flash, radio}, 5'h0)
      far.pads(~pad);
      far.fire(0);
      repeat (20) @(negedge clk);
      `CHK({cpu, hv}, {1'b0, pad})
      apb(1'b1, REG_CTRL, 32'h1);
      far.fire(k);
      wake(STBY_WAKE_CYC);
      `CHK(resume, 1'b1)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd, 32'h1)
    end
    far.pads(32'h1234_ABCD);
    apb(1'b1, REG_CTRL, 32'h3);
    repeat (3) @(negedge clk);
    `CHK({sysr, always_on_domain, sens, slow, sram, hv}, {8'h00, 32'h1234_ABCD})
    far.fire(3);
    wake(SHDN_WAKE_CYC);
    `CHK(resume, 1'b0)
    apb(1'b0, REG_RST_CAUSE, 32'h0);
    `CHK(rd, 32'h4)
    apb(1'b0, REG_SRAM_RET, 32'h0);
    `CHK(rd, 32'h0)
    far.hold_reset();
    repeat (6) @(negedge clk);
    `CHK({sysr, fast, flash, radio, slow}, 5'h0)
    apb(1'b0, REG_RST_CAUSE, 32'h0);
    `CHK(rd, 32'h2)
    print_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/pmc_pkg.sv
// Constants, register map and state codes for the power mode controller.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package pmc_pkg;

  localparam int unsigned CLK_MHZ = 50;
  // Wake latencies in microseconds and their cycle counts at the clock rate.
  localparam int unsigned IDLE_WAKE_US = 14;
  localparam int unsigned STBY_WAKE_US = 151;
  localparam int unsigned SHDN_WAKE_US = 1015;
  localparam int unsigned IDLE_WAKE_CYC = IDLE_WAKE_US * CLK_MHZ;
  localparam int unsigned STBY_WAKE_CYC = STBY_WAKE_US * CLK_MHZ;
  localparam int unsigned SHDN_WAKE_CYC = SHDN_WAKE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;

  // Register byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RST_CAUSE = 8'h08;
  localparam logic [7:0] REG_SRAM_RET = 8'h0C;
  localparam logic [7:0] REG_WAKE_PIN = 8'h10;
  localparam logic [7:0] REG_CLK_CFG = 8'h14;

  // Control register fields.
  localparam int unsigned CTRL_REQ_LSB = 0;
  localparam int unsigned CTRL_REQ_W = 2;
  localparam int unsigned CTRL_CACHE_OFF_BIT = 2;
  // Clock configuration fields.
  localparam int unsigned CLK_FAST_RC_BIT = 0;
  localparam int unsigned CLK_SLOW_RC_BIT = 1;
  // Reset cause field positions.
  localparam int unsigned RC_POR_BIT = 0;
  localparam int unsigned RC_PIN_BIT = 1;
  localparam int unsigned RC_WAKE_BIT = 2;

  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_IDLE = 2'h1;
  localparam logic [1:0] REQ_STBY = 2'h2;
  localparam logic [1:0] REQ_SHDN = 2'h3;

  localparam int unsigned SRAM_BLOCKS = 4;
  localparam int unsigned IO_W = 32;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [2:0] CAUSE_POR = 3'h1;

  typedef enum logic [5:0] {
    PMC_ACTIVE = 6'b000001,
    PMC_IDLE = 6'b000010,
    PMC_STBY = 6'b000100,
    PMC_SHDN = 6'b001000,
    PMC_RSTHELD = 6'b010000,
    PMC_WAKING = 6'b100000
  } pmc_state_t;

  typedef struct packed {
    pmc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] req;
    logic cache_off;
    logic [1:0] clk_cfg;
    logic [SRAM_BLOCKS-1:0] sram_ret;
    logic [IO_W-1:0] wake_en;
    logic [2:0] cause;
    logic [IO_W-1:0] io_hold;
    logic io_latched;
    logic [IO_W-1:0] pin_s1;
    logic [IO_W-1:0] pin_s2;
    logic [IO_W-1:0] pin_s3;
    logic [2:0] ev_s1;
    logic [2:0] ev_s2;
    logic [1:0] rstp_s;
    logic [31:0] prdata;
  } pmc_regs_t;

endpackage

// File: verilog/pmc_power_mode_controller.sv
// Power mode controller: mode state machine, domain enables and APB registers.
// Assumes wake pins, reset pin and wake events arrive asynchronously.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PIN_RESET_N,
  input wire logic [pmc_pkg::IO_W-1:0] WAKE_PINS,
  input wire logic IRQ_ANY,
  input wire logic RTC_EVENT,
  input wire logic SENSOR_EVENT,
  input wire logic [pmc_pkg::IO_W-1:0] GPIO_LIVE,
  output logic [pmc_pkg::IO_W-1:0] GPIO_HOLD_VAL,
  output logic GPIO_LATCH,
  output logic CPU_CLK_EN,
  output logic CPU_RESUME,
  output logic FLASH_PWR,
  output logic RADIO_EN,
  output logic FAST_CLK_EN,
  output logic FAST_CLK_SEL_RC,
  output logic PLL_DOUBLER_EN,
  output logic SLOW_CLK_EN,
  output logic SLOW_CLK_SEL_RC,
  output logic PERIPH_PWR,
  output logic ALWAYS_ON_PWR,
  output logic SENSOR_PWR,
  output logic REG_RETAIN,
  output logic [pmc_pkg::SRAM_BLOCKS-1:0] SRAM_PWR,
  output logic CACHE_AS_RAM,
  output logic BROWNOUT_EN,
  output logic POR_EN,
  output logic SYS_RESET_N
);
  import pmc_pkg::*;

  pmc_regs_t r_ff;
  pmc_regs_t nxt_r;
  logic wr;
  logic rd;
  logic pin_change;
  logic rst_pin_held;

  // Decodes a register address into its read value.
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input pmc_regs_t s);
    logic [31:0] v;
    v = ZERO32;
    unique case (a)
      REG_CTRL: v = {29'h0000_0000, s.cache_off, s.req};
      REG_STATUS: v = {26'h000_0000, s.state};
      REG_RST_CAUSE: v = {29'h0000_0000, s.cause};
      REG_SRAM_RET: v = {28'h000_0000, s.sram_ret};
      REG_WAKE_PIN: v = s.wake_en;
      REG_CLK_CFG: v = {30'h0000_0000, s.clk_cfg};
      default: v = ZERO32;
    endcase
    return v;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_RST_CAUSE) ||
      (a == REG_SRAM_RET) || (a == REG_WAKE_PIN) || (a == REG_CLK_CFG);
  endfunction

  // Supply and clock enables that follow from the mode alone.
  typedef struct packed {
    logic cpu_clk;
    logic flash;
    logic radio;
    logic fast_clk;
    logic slow_clk;
    logic periph;
    logic always_on;
    logic sensor;
    logic reg_retain;
    logic sram_all;
    logic brownout;
    logic por;
    logic sys_run;
  } pmc_dom_t;

  // Waking already powers what active needs except the processor clock, the radio and brownout, so supplies settle before the processor runs.
  function automatic pmc_dom_t mode_domains(input pmc_state_t s);
    pmc_dom_t d;
    d = '0;
    unique case (s)
      PMC_ACTIVE:
      begin
        d.cpu_clk = 1'b1;
        d.flash = 1'b1;
        d.radio = 1'b1;
        d.fast_clk = 1'b1;
        d.slow_clk = 1'b1;
        d.periph = 1'b1;
        d.always_on = 1'b1;
        d.sensor = 1'b1;
        d.reg_retain = 1'b1;
        d.sram_all = 1'b1;
        d.brownout = 1'b1;
        d.por = 1'b1;
        d.sys_run = 1'b1;
      end
      PMC_IDLE:
      begin
        d.flash = 1'b1;
        d.radio = 1'b1;
        d.fast_clk = 1'b1;
        d.slow_clk = 1'b1;
        d.periph = 1'b1;
        d.always_on = 1'b1;
        d.sensor = 1'b1;
        d.reg_retain = 1'b1;
        d.sram_all = 1'b1;
        d.brownout = 1'b1;
        d.por = 1'b1;
        d.sys_run = 1'b1;
      end
      PMC_STBY:
      begin
        d.slow_clk = 1'b1;
        d.always_on = 1'b1;
        d.sensor = 1'b1;
        d.reg_retain = 1'b1;
        d.por = 1'b1;
        d.sys_run = 1'b1;
      end
      PMC_SHDN:
      begin
        d.brownout = 1'b1;
        d.por = 1'b1;
      end
      PMC_RSTHELD:
      begin
        d.always_on = 1'b1;
        d.sensor = 1'b1;
      end
      PMC_WAKING:
      begin
        d.flash = 1'b1;
        d.fast_clk = 1'b1;
        d.slow_clk = 1'b1;
        d.periph = 1'b1;
        d.always_on = 1'b1;
        d.sensor = 1'b1;
        d.reg_retain = 1'b1;
        d.sram_all = 1'b1;
        d.por = 1'b1;
        d.sys_run = 1'b1;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign rst_pin_held = !r_ff.rstp_s[1];
  // Only the second and third stages are compared, never the first.
  assign pin_change = |((r_ff.pin_s2 ^ r_ff.pin_s3) & r_ff.wake_en);

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.pin_s1 = WAKE_PINS;
    nxt_r.pin_s2 = r_ff.pin_s1;
    nxt_r.pin_s3 = r_ff.pin_s2;
    nxt_r.ev_s1 = {SENSOR_EVENT, RTC_EVENT, IRQ_ANY};
    nxt_r.ev_s2 = r_ff.ev_s1;
    nxt_r.rstp_s = {r_ff.rstp_s[0], PIN_RESET_N};
    if (rd)
    begin
      nxt_r.prdata = rd_mux(PADDR, r_ff);
    end
    if (wr && (PADDR == REG_CTRL))
    begin
      // A request made outside active mode is dropped, so it cannot fire after a wake.
      if (r_ff.state == PMC_ACTIVE)
      begin
        nxt_r.req = PWDATA[CTRL_REQ_LSB +: CTRL_REQ_W];
      end
      nxt_r.cache_off = PWDATA[CTRL_CACHE_OFF_BIT];
    end
    if (wr && (PADDR == REG_SRAM_RET))
    begin
      nxt_r.sram_ret = PWDATA[SRAM_BLOCKS-1:0];
    end
    if (wr && (PADDR == REG_WAKE_PIN))
    begin
      nxt_r.wake_en = PWDATA;
    end
    if (wr && (PADDR == REG_CLK_CFG))
    begin
      nxt_r.clk_cfg = PWDATA[1:0];
    end
    if (wr && (PADDR == REG_RST_CAUSE))
    begin
      // Write one to clear.
      nxt_r.cause = r_ff.cause & ~PWDATA[2:0];
    end
    unique case (r_ff.state)
      PMC_ACTIVE:
      begin
        if (r_ff.req == REQ_IDLE)
        begin
          nxt_r.state = PMC_IDLE;
          nxt_r.req = REQ_NONE;
        end
        else if (r_ff.req == REQ_STBY)
        begin
          nxt_r.state = PMC_STBY;
          nxt_r.io_hold = GPIO_LIVE;
          nxt_r.io_latched = 1'b1;
          nxt_r.req = REQ_NONE;
        end
        else if (r_ff.req == REQ_SHDN)
        begin
          nxt_r.state = PMC_SHDN;
          nxt_r.io_hold = GPIO_LIVE;
          nxt_r.io_latched = 1'b1;
          nxt_r.req = REQ_NONE;
        end
      end
      PMC_IDLE:
      begin
        if (r_ff.ev_s2[0] || pin_change)
        begin
          nxt_r.state = PMC_WAKING;
          nxt_r.cnt = CNT_W'(IDLE_WAKE_CYC - 1);
        end
      end
      PMC_STBY:
      begin
        if (pin_change || r_ff.ev_s2[1] || r_ff.ev_s2[2])
        begin
          nxt_r.state = PMC_WAKING;
          nxt_r.cnt = CNT_W'(STBY_WAKE_CYC - 1);
        end
      end
      PMC_SHDN:
      begin
        if (pin_change)
        begin
          nxt_r.state = PMC_WAKING;
          nxt_r.cnt = CNT_W'(SHDN_WAKE_CYC - 1);
          nxt_r.cause = 3'h1 << RC_WAKE_BIT;
          nxt_r.req = REQ_NONE;
          nxt_r.sram_ret = '0;
          nxt_r.wake_en = '0;
          nxt_r.cache_off = 1'b0;
          nxt_r.clk_cfg = '0;
        end
      end
      PMC_RSTHELD:
      begin
        if (!rst_pin_held)
        begin
          nxt_r.state = PMC_WAKING;
          nxt_r.cnt = CNT_W'(SHDN_WAKE_CYC - 1);
        end
      end
      PMC_WAKING:
      begin
        if (r_ff.cnt == '0)
        begin
          nxt_r.state = PMC_ACTIVE;
          nxt_r.io_latched = 1'b0;
        end
        else
        begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
        end
      end
      default: nxt_r.state = PMC_ACTIVE;
    endcase
    // Reset pin wins from any mode; state is lost as in shutdown.
    if (rst_pin_held)
    begin
      nxt_r.state = PMC_RSTHELD;
      nxt_r.cause = {2'h0, 1'b0} | (3'h1 << RC_PIN_BIT);
      nxt_r.req = REQ_NONE;
      nxt_r.sram_ret = '0;
      nxt_r.wake_en = '0;
      nxt_r.cache_off = 1'b0;
      nxt_r.clk_cfg = '0;
      nxt_r.io_latched = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r_ff <= '{state: PMC_ACTIVE, cause: CAUSE_POR, rstp_s: 2'h3, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  pmc_dom_t dom;
  logic st_stby;
  assign dom = mode_domains(r_ff.state);
  assign st_stby = (r_ff.state == PMC_STBY);

  // Waking counts as the tail of the low-power state, so domains come up early.
  assign PRDATA = r_ff.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok(PADDR);
  assign GPIO_HOLD_VAL = r_ff.io_hold;
  assign GPIO_LATCH = r_ff.io_latched;
  assign CPU_CLK_EN = dom.cpu_clk;
  // Any pending reset cause means the processor starts afresh rather than resuming.
  assign CPU_RESUME = dom.cpu_clk && !(|r_ff.cause);
  assign FLASH_PWR = dom.flash;
  assign RADIO_EN = dom.radio;
  assign FAST_CLK_EN = dom.fast_clk;
  assign FAST_CLK_SEL_RC = r_ff.clk_cfg[CLK_FAST_RC_BIT];
  assign PLL_DOUBLER_EN = dom.fast_clk && !r_ff.clk_cfg[CLK_FAST_RC_BIT];
  assign SLOW_CLK_EN = dom.slow_clk;
  assign SLOW_CLK_SEL_RC = r_ff.clk_cfg[CLK_SLOW_RC_BIT];
  assign PERIPH_PWR = dom.periph;
  assign ALWAYS_ON_PWR = dom.always_on;
  assign SENSOR_PWR = dom.sensor;
  assign REG_RETAIN = dom.reg_retain;
  assign CACHE_AS_RAM = r_ff.cache_off;
  assign BROWNOUT_EN = dom.brownout;
  assign POR_EN = dom.por;
  assign SYS_RESET_N = dom.sys_run;

  // Only retained blocks stay powered in standby; none in shutdown.
  genvar g;
  generate
    for (g = 0; g < SRAM_BLOCKS; g++)
    begin : g_sram
      assign SRAM_PWR[g] = (st_stby ? r_ff.sram_ret[g] : dom.sram_all);
    end
  endgenerate
endmodule
`default_nettype wire
